// file: design/supply_status_defs.svh
`ifndef SUPPLY_STATUS_DEFS_SVH
`define SUPPLY_STATUS_DEFS_SVH

// ---------------------------------------------
// Register addresses (7-bit frame address)
// ---------------------------------------------
`define ADDR_SUPPLY_A 7'h40
`define ADDR_SUPPLY_B 7'h41
`define ADDR_THERMAL 7'h42
`define ADDR_HISTORY 7'h43

// ---------------------------------------------
// Implemented bits and reset values
// ---------------------------------------------
`define MASK_SUPPLY_A 8'h5F
`define MASK_SUPPLY_B 8'hFF
`define MASK_THERMAL 8'h07
`define MASK_HISTORY_CLR 8'hC3
`define RST_SUPPLY_B_POR 8'h80
`define RST_SOFT 8'h00

// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define POS_POR 7
`define POS_PRIOR_HI 7
`define POS_PRIOR_LO 6
`define POS_WDCNT_HI 3
`define POS_WDCNT_LO 2
`define POS_SPI_FAIL 1
`define POS_FAILURE 0

// ---------------------------------------------
// Codes
// ---------------------------------------------
`define PRIOR_CLEARED 2'h0
`define PRIOR_FAILURE 2'h1
`define PRIOR_SLEEP 2'h2
`define WD_CFG_TWO 2'h1
`define WD_CFG_FOUR 2'h3
`define WD_LIMIT_ONE 2'h1
`define WD_LIMIT_TWO 2'h2

// ---------------------------------------------
// Frame and timing
// ---------------------------------------------
`define FRAME_BITS 5'h10
`define ADDR_LAST_BIT 5'h07
`define BIT_CNT_MAX 5'h1F
`define CLK_MHZ 50
`define SHORT_TIME_US 4000
`define SHORT_CYCLES (`SHORT_TIME_US * `CLK_MHZ)

`endif

// file: design/supply_status_pkg.sv
package supply_status_pkg;

   typedef enum logic [2:0] {
      MODE_INIT,
      MODE_NORMAL,
      MODE_STOP,
      MODE_SLEEP,
      MODE_RESTART,
      MODE_FAILSAFE
   } op_mode_t;

   typedef enum logic [1:0] {
      SPI_IDLE,
      SPI_ADDR,
      SPI_DATA
   } spi_state_t;

   // One-cycle detection pulses, except main_uv_level
   typedef struct packed {
      logic battery_uv;
      logic aux3_oc;
      logic aux3_uv;
      logic aux3_ot;
      logic main_ov;
      logic main_warn;
      logic hs_uv;
      logic hs_ov;
      logic second_ot;
      logic second_uv;
      logic main_uv_level;
      logic main_uv_reset;
      logic repeat_uv_failsafe;
      logic thermal_shutdown_stage_two;
      logic thermal_shutdown_stage_one;
      logic thermal_prewarning_flag;
   } supply_events_t;

   typedef struct packed {
      logic watchdog_failure_counter;
      logic wd_trigger_ok;
      logic wd_stopped;
      logic wd_stop_by_fail;
      logic fail_output_act;
      logic failure_restart;
      logic illegal_stop_sleep;
      logic no_wake_sleep;
      logic sleep_restart;
      logic sleep_flags_uncleared;
      logic soft_reset;
   } history_events_t;

   typedef struct packed {
      logic [7:0] supply_a;
      logic [7:0] supply_b;
      logic [7:0] thermal;
      logic [7:0] history;
   } status_view_t;

endpackage

// file: design/supply_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "supply_status_defs.svh"

// How it works
// - Reserved bits always read zero and clear commands leave them alone.
// - First supply register latches battery undervoltage, main overvoltage, main prewarning.
// - First supply register latches third regulator overcurrent, undervoltage, overtemperature.
// - Power-on flag reads one after power-on, zero after soft reset.
// - Second supply register latches high-side supply undervoltage and overvoltage.
// - Second supply register latches second regulator overtemperature and undervoltage.
// - Main output below threshold over 4 ms after switch-on sets short flag.
// - Fail-safe entry after fourth consecutive main undervoltage reset sets its flag.
// - Main undervoltage failure causing reset latches bit 0.
// - In sleep with main regulator off, short, overvoltage, undervoltage stay unset.
// - Main undervoltage updates by mode; in restart only during short; always during short.
// - Thermal register latches shutdown stage two, stage one, prewarning.
// - Thermal flags stay set after condition leaves until host clears.
// - Prior-state field: 00 cleared, 01 failure, 10 sleep, 11 unused.
// - Illegal stop-to-sleep or sleep without wake source reports failure code.
// - Sleep attempt with wake flags still set reports sleep code.
// - Read-only watchdog failure counter saturates at 01 or 10, never 11.
// - Counter clears on good trigger or watchdog stop not caused by failure.
// - Configurations two and four keep a nonzero counter through watchdog stops until good trigger.
// - With strap low, first watchdog failure activates neither fail output nor flag.
// - Invalid serial command sets its flag; only host clear or soft reset resets it.
// - Fail output activation sets failure flag until host clears it.
// - Frame is 16 bits: 7-bit address, mode bit, data byte.
// - Mode bit one clears the addressed register; zero only reads.
module supply_status_regs
   import supply_status_pkg::*;
#(
   parameter int SHORT_CYCLES = `SHORT_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic spi_csn_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic miso_r,
   output logic miso_oe_r,
   input wire logic cfg_strap,
   input wire logic [1:0] wd_config,
   input wire op_mode_t mode,
   input wire logic main_reg_off,
   input wire logic reset_output,
   input wire supply_events_t sev,
   input wire history_events_t hev,
   output status_view_t regs_r,
   output logic failsafe_req_r,
   output logic watchdog_failure_counter_output_req_r
);

   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   logic csn_s1, csn_s2, csn_d;
   logic sclk_s1, sclk_s2, sclk_d;
   logic mosi_s1, mosi_s2;
   logic strap_s1, strap_s2;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         csn_s1 <= 1'b1;
         csn_s2 <= 1'b1;
         csn_d <= 1'b1;
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_d <= 1'b0;
         mosi_s1 <= 1'b0;
         mosi_s2 <= 1'b0;
         strap_s1 <= 1'b0;
         strap_s2 <= 1'b0;
      end else begin
         csn_s1 <= spi_csn_n;
         csn_s2 <= csn_s1;
         csn_d <= csn_s2;
         sclk_s1 <= spi_sclk;
         sclk_s2 <= sclk_s1;
         sclk_d <= sclk_s2;
         mosi_s1 <= spi_mosi;
         mosi_s2 <= mosi_s1;
         strap_s1 <= cfg_strap;
         strap_s2 <= strap_s1;
      end
   end

   logic sclk_rise, sclk_fall, frame_start, frame_end;
   assign sclk_rise = sclk_s2 & ~sclk_d;
   assign sclk_fall = ~sclk_s2 & sclk_d;
   assign frame_start = ~csn_s2 & csn_d;
   assign frame_end = csn_s2 & ~csn_d;

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic [7:0] read_reg(input logic [6:0] a, input status_view_t r);
      case (a)
         `ADDR_SUPPLY_A: read_reg = r.supply_a;
         `ADDR_SUPPLY_B: read_reg = r.supply_b;
         `ADDR_THERMAL: read_reg = r.thermal;
         `ADDR_HISTORY: read_reg = r.history;
         default: read_reg = 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] clr_mask(input logic req, input logic [6:0] a,
                                           input logic [6:0] target, input logic [7:0] m);
      clr_mask = (req && a == target) ? m : 8'h00;
   endfunction

   // ---------------------------------------------
   // Serial frame receiver
   // ---------------------------------------------
   spi_state_t state_r;
   logic [4:0] bit_cnt_r;
   logic [15:0] shift_r;
   logic [7:0] snap_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= SPI_IDLE;
         bit_cnt_r <= 5'h00;
         shift_r <= 16'h0000;
      end else begin
         case (state_r)
            SPI_IDLE: begin
               if (frame_start) begin
                  state_r <= SPI_ADDR;
                  bit_cnt_r <= 5'h00;
                  shift_r <= 16'h0000;
               end
            end
            SPI_ADDR: begin
               if (frame_end) begin
                  state_r <= SPI_IDLE;
               end else if (sclk_rise) begin
                  shift_r[bit_cnt_r[3:0]] <= mosi_s2;
                  bit_cnt_r <= bit_cnt_r + 5'h01;
                  if (bit_cnt_r == `ADDR_LAST_BIT) begin
                     state_r <= SPI_DATA;
                  end
               end
            end
            SPI_DATA: begin
               if (frame_end) begin
                  state_r <= SPI_IDLE;
               end else if (sclk_rise) begin
                  if (bit_cnt_r < `FRAME_BITS) begin
                     shift_r[bit_cnt_r[3:0]] <= mosi_s2;
                  end
                  // Saturate so an overlong frame stays detectable
                  if (bit_cnt_r != `BIT_CNT_MAX) begin
                     bit_cnt_r <= bit_cnt_r + 5'h01;
                  end
               end
            end
            default: begin
               state_r <= SPI_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------
   // Response shifter
   // ---------------------------------------------

   // Response byte captured once address is complete
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         snap_r <= 8'h00;
      end else if (state_r == SPI_ADDR && sclk_rise && bit_cnt_r == `ADDR_LAST_BIT) begin
         snap_r <= read_reg(shift_r[6:0], regs_r);
      end
   end

   // Address byte answers zero; data byte returns snapshot LSB first
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         miso_r <= 1'b0;
         miso_oe_r <= 1'b0;
      end else begin
         if (frame_start) begin
            miso_oe_r <= 1'b1;
            miso_r <= 1'b0;
         end else if (frame_end) begin
            miso_oe_r <= 1'b0;
            miso_r <= 1'b0;
         end else if (sclk_fall && state_r == SPI_DATA && bit_cnt_r < `FRAME_BITS) begin
            miso_r <= snap_r[bit_cnt_r[2:0]];
         end
      end
   end

   // ---------------------------------------------
   // Frame decode
   // ---------------------------------------------

   // Short or long frames act on nothing, only flag
   logic frame_ok, clr_req, spi_invalid;
   logic [6:0] clr_addr;
   assign frame_ok = frame_end && state_r == SPI_DATA && bit_cnt_r == `FRAME_BITS;
   assign clr_req = frame_ok && shift_r[7];
   assign clr_addr = shift_r[6:0];
   assign spi_invalid = frame_end && state_r != SPI_IDLE && !frame_ok;

   // ---------------------------------------------
   // Main regulator qualification
   // ---------------------------------------------
   logic [17:0] short_cnt_r;
   logic short_cond_r;
   logic ro_seen_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         short_cnt_r <= 18'h00000;
         short_cond_r <= 1'b0;
      end else if (!sev.main_uv_level || main_reg_off) begin
         short_cnt_r <= 18'h00000;
         short_cond_r <= 1'b0;
      end else if (short_cnt_r == 18'(SHORT_CYCLES)) begin
         short_cond_r <= 1'b1;
      end else begin
         short_cnt_r <= short_cnt_r + 18'h00001;
      end
   end

   // ---------------------------------------------
   // Mode gating
   // ---------------------------------------------

   // Remembers first reset release since the last restart
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ro_seen_r <= 1'b0;
      end else if (mode == MODE_RESTART) begin
         ro_seen_r <= 1'b0;
      end else if (reset_output) begin
         ro_seen_r <= 1'b1;
      end
   end

   logic sleep_off, uv_update_ok;
   assign sleep_off = mode == MODE_SLEEP && main_reg_off;
   always_comb begin
      case (mode)
         MODE_NORMAL, MODE_STOP: uv_update_ok = 1'b1;
         MODE_INIT: uv_update_ok = ro_seen_r || short_cond_r;
         MODE_RESTART: uv_update_ok = short_cond_r;
         default: uv_update_ok = short_cond_r;
      endcase
   end

   // ---------------------------------------------
   // Watchdog failure counter
   // ---------------------------------------------
   logic [1:0] wd_cnt_r;
   logic [1:0] wd_limit;
   logic wd_frozen;
   assign wd_limit = (wd_config == `WD_CFG_TWO) ? `WD_LIMIT_ONE : `WD_LIMIT_TWO;
   assign wd_frozen = (wd_config == `WD_CFG_TWO || wd_config == `WD_CFG_FOUR) &&
                      wd_cnt_r != 2'h0;

   always_ff @(posedge clk) begin
      if (sys_rst || hev.soft_reset) begin
         wd_cnt_r <= 2'h0;
      end else if (hev.wd_trigger_ok) begin
         wd_cnt_r <= 2'h0;
      end else if (hev.watchdog_failure_counter && wd_cnt_r < wd_limit) begin
         wd_cnt_r <= wd_cnt_r + 2'h1;
      end else if (hev.wd_stopped && !hev.wd_stop_by_fail && !wd_frozen) begin
         wd_cnt_r <= 2'h0;
      end
   end

   // Strap low spares the first failure from the fail output
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         watchdog_failure_counter_output_req_r <= 1'b0;
      end else begin
         watchdog_failure_counter_output_req_r <= hev.watchdog_failure_counter && wd_cnt_r + 2'h1 >= wd_limit &&
                                 !(!strap_s2 && wd_cnt_r == 2'h0);
      end
   end

   // ---------------------------------------------
   // Fail-safe request
   // ---------------------------------------------

   // Registered so the mode logic sees a clean pulse
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         failsafe_req_r <= 1'b0;
      end else begin
         failsafe_req_r <= sev.thermal_shutdown_stage_two;
      end
   end

   // ---------------------------------------------
   // Status flags
   // ---------------------------------------------
   logic [7:0] set_a, set_b, set_t, set_h;
   logic [7:0] clr_a, clr_b, clr_t, clr_h;
   logic [1:0] prior_nxt;

   assign set_a = {1'b0, sev.battery_uv, 1'b0, sev.aux3_oc, sev.aux3_uv,
                   sev.aux3_ot, sev.main_ov && !sleep_off, sev.main_warn};
   assign set_b = {1'b0, sev.hs_uv, sev.hs_ov, sev.second_ot,
                   sev.second_uv, short_cond_r && !sleep_off,
                   sev.repeat_uv_failsafe,
                   sev.main_uv_reset && uv_update_ok && !sleep_off};
   assign set_t = {5'h00, sev.thermal_shutdown_stage_two, sev.thermal_shutdown_stage_one, sev.thermal_prewarning_flag};
   assign set_h = {6'h00, spi_invalid,
                   hev.fail_output_act || watchdog_failure_counter_output_req_r};

   // ---------------------------------------------
   // Clear masks
   // ---------------------------------------------

   assign clr_a = clr_mask(clr_req, clr_addr, `ADDR_SUPPLY_A, `MASK_SUPPLY_A);
   assign clr_b = clr_mask(clr_req, clr_addr, `ADDR_SUPPLY_B, `MASK_SUPPLY_B);
   assign clr_t = clr_mask(clr_req, clr_addr, `ADDR_THERMAL, `MASK_THERMAL);
   assign clr_h = clr_mask(clr_req, clr_addr, `ADDR_HISTORY, `MASK_HISTORY_CLR);

   // ---------------------------------------------
   // Prior-state field
   // ---------------------------------------------

   always_comb begin
      prior_nxt = regs_r.history[`POS_PRIOR_HI:`POS_PRIOR_LO];
      if (clr_h[`POS_PRIOR_HI]) begin
         prior_nxt = `PRIOR_CLEARED;
      end
      // Failure outranks sleep when both arrive together
      if (hev.failure_restart || hev.illegal_stop_sleep || hev.no_wake_sleep) begin
         prior_nxt = `PRIOR_FAILURE;
      end else if (hev.sleep_restart || hev.sleep_flags_uncleared) begin
         prior_nxt = `PRIOR_SLEEP;
      end
   end

   // ---------------------------------------------
   // Register update
   // ---------------------------------------------

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         regs_r.supply_a <= `RST_SOFT;
         regs_r.supply_b <= `RST_SUPPLY_B_POR;
         regs_r.thermal <= `RST_SOFT;
         regs_r.history <= `RST_SOFT;
      end else if (hev.soft_reset) begin
         regs_r.supply_a <= `RST_SOFT;
         regs_r.supply_b <= `RST_SOFT;
         regs_r.thermal <= `RST_SOFT;
         regs_r.history <= `RST_SOFT;
      end else begin
         regs_r.supply_a <= ((regs_r.supply_a & ~clr_a) | set_a) & `MASK_SUPPLY_A;
         regs_r.supply_b <= (regs_r.supply_b & ~clr_b) | set_b;
         regs_r.thermal <= ((regs_r.thermal & ~clr_t) | set_t) & `MASK_THERMAL;
         regs_r.history[`POS_PRIOR_HI:`POS_PRIOR_LO] <= prior_nxt;
         regs_r.history[5:4] <= 2'h0;
         regs_r.history[`POS_WDCNT_HI:`POS_WDCNT_LO] <= wd_cnt_r;
         regs_r.history[`POS_SPI_FAIL] <= (regs_r.history[`POS_SPI_FAIL] &
                                           ~clr_h[`POS_SPI_FAIL]) | set_h[`POS_SPI_FAIL];
         regs_r.history[`POS_FAILURE] <= (regs_r.history[`POS_FAILURE] &
                                          ~clr_h[`POS_FAILURE]) | set_h[`POS_FAILURE];
      end
   end

endmodule
`default_nettype wire

// file: bench/supply_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module supply_status_asserts
   import supply_status_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [1:0] wd_config,
   input wire op_mode_t mode,
   input wire logic main_reg_off,
   input wire logic spi_csn_n,
   input wire supply_events_t sev,
   input wire history_events_t hev,
   input wire status_view_t regs_r,
   input wire logic failsafe_req_r,
   input wire logic watchdog_failure_counter_output_req_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [1:0] cnt;
   logic [3:0] sticky;
   assign cnt = regs_r.history[3:2];
   assign sticky = {regs_r.history[1:0], regs_r.supply_b[7], |regs_r.thermal};
   // ---------------------------------------------
   // Register invariants
   // ---------------------------------------------
   AST_RESERVED_ZERO: assert property ({regs_r.supply_a[7], regs_r.supply_a[5]} == 2'h0
      && regs_r.thermal[7:3] == 5'h00 && regs_r.history[5:4] == 2'h0)
      else $error("reserved bit set");
   AST_CNT_NEVER_THREE: assert property (cnt != 2'h3)
      else $error("wd counter reached 3");
   // Flags only drop a few cycles after a frame or on soft reset
   AST_THERMAL_STICKY: assert property ((|($past(regs_r.thermal) & ~regs_r.thermal))
      |-> ($past(hev.soft_reset) || $past(spi_csn_n, 2)))
      else $error("thermal flag dropped");
   AST_FLAG_STICKY: assert property ((|($past(sticky[3:1]) & ~sticky[3:1]))
      |-> ($past(hev.soft_reset) || $past(spi_csn_n, 2)))
      else $error("history flag dropped");
   AST_CNT_CLEAR: assert property (($past(cnt) != 2'h0 && cnt == 2'h0)
      |-> ($past(hev.wd_trigger_ok, 2) || $past(hev.wd_stopped, 2) || $past(hev.soft_reset)))
      else $error("wd counter cleared without cause");
   AST_CNT_FREEZE: assert property ((hev.wd_stopped && wd_config[0] && cnt != 2'h0
      && !hev.wd_trigger_ok && !hev.watchdog_failure_counter && !hev.soft_reset) |-> ##2 $stable(cnt))
      else $error("wd counter not frozen");
   // ---------------------------------------------
   // Event latching
   // ---------------------------------------------
   AST_SLEEP_BLOCK: assert property (($rose(regs_r.supply_a[1]) || $rose(regs_r.supply_b[2])
      || $rose(regs_r.supply_b[0])) |-> !($past(mode) == MODE_SLEEP && $past(main_reg_off)))
      else $error("main flag set in sleep");
   AST_RESTART_BLOCK: assert property ($rose(regs_r.supply_b[0])
      |-> ($past(mode) != MODE_RESTART || regs_r.supply_b[2]))
      else $error("undervoltage set in restart");
   AST_LATCH_BATTERY: assert property (sev.battery_uv |=> regs_r.supply_a[6])
      else $error("battery flag missed");
   AST_THERMAL_SHUTDOWN_STAGE_TWO_FAILSAFE: assert property (sev.thermal_shutdown_stage_two |=> (failsafe_req_r && regs_r.thermal[2]))
      else $error("stage two missed");
   AST_FAIL_OUTPUT: assert property ((hev.fail_output_act || watchdog_failure_counter_output_req_r)
      |=> regs_r.history[0])
      else $error("failure flag missed");
   cover property (sev.thermal_shutdown_stage_two);
   cover property ($rose(regs_r.supply_b[2]));
   cover property (watchdog_failure_counter_output_req_r);
   cover property ($fell(sticky[0]));
endmodule
`default_nettype wire

// file: bench/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input wire logic clk,
   input wire logic miso,
   input wire logic miso_oe,
   output logic csn_n,
   output logic sclk,
   output logic mosi
);
   initial begin
      csn_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   // Half period of 5 clocks stays above the 4-clock sync floor
   task automatic frame(input logic [6:0] addr, input logic clr, input int rises,
                        output logic [7:0] rd);
      logic [15:0] word;
      word = {8'h00, clr, addr};
      rd = 8'h00;
      csn_n = 1'b0;
      repeat (6) @(negedge clk);
      for (int i = 0; i < rises; i++) begin
         mosi = word[i];
         repeat (5) @(negedge clk);
         // Undriven answer line must never pass as data
         if (i >= 8) rd[i - 8] = miso_oe ? miso : 1'bx;
         sclk = 1'b1;
         repeat (5) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (5) @(negedge clk);
      csn_n = 1'b1;
      mosi = ~mosi;
      repeat (8) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "supply_status_defs.svh"
`define CHK(what, exp, got) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("unexpected %s: expected %h, seen %h", what, exp, got); \
      end \
   end
module testbench;
   import supply_status_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cfg_strap = 1'b1;
   logic [1:0] wd_config = 2'h0;
   op_mode_t mode = MODE_NORMAL;
   logic main_reg_off = 1'b0;
   logic reset_output = 1'b1;
   supply_events_t sev = '0;
   history_events_t hev = '0;
   logic spi_csn_n;
   logic spi_sclk;
   logic spi_mosi;
   logic miso_r;
   logic miso_oe_r;
   logic failsafe_req_r;
   logic watchdog_failure_counter_output_req_r;
   status_view_t regs_r;
   int fails = 0;
   int total_checks = 0;
   logic [7:0] rd;
   history_events_t hv[6] = '{11'h020, 11'h004, 11'h010, 11'h008, 11'h002, 11'h024};
   logic [1:0] code[6] = '{2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1};
   always #10 clk = ~clk;
   supply_status_regs #(.SHORT_CYCLES(20)) supply_status_regs_inst (
      .clk(clk), .sys_rst(sys_rst), .spi_csn_n(spi_csn_n), .spi_sclk(spi_sclk),
      .spi_mosi(spi_mosi), .miso_r(miso_r), .miso_oe_r(miso_oe_r), .cfg_strap(cfg_strap),
      .wd_config(wd_config), .mode(mode), .main_reg_off(main_reg_off),
      .reset_output(reset_output), .sev(sev), .hev(hev), .regs_r(regs_r),
      .failsafe_req_r(failsafe_req_r), .watchdog_failure_counter_output_req_r(watchdog_failure_counter_output_req_r));
   spi_host_model spi_host_model_inst (.clk(clk), .miso(miso_r), .miso_oe(miso_oe_r),
      .csn_n(spi_csn_n), .sclk(spi_sclk), .mosi(spi_mosi));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic xfer(input logic [6:0] a, input logic c, input int rises, input logic [7:0] e);
      spi_host_model_inst.frame(a, c, rises, rd);
      if (rises == 16) `CHK("spi data", e, rd)
   endtask
   task automatic pulse(input supply_events_t s, input history_events_t h);
      sev = s;
      hev = h;
      @(negedge clk);
      sev = '0;
      hev = '0;
      @(negedge clk);
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      `CHK("reset view", 32'h0080_0000, regs_r)
      xfer(`ADDR_SUPPLY_B, 1'b0, 16, 8'h80);
      xfer(`ADDR_SUPPLY_B, 1'b0, 16, 8'h80);
      xfer(7'h50, 1'b1, 16, 8'h00);
      xfer(`ADDR_HISTORY, 1'b0, 15, 8'h00);
      `CHK("spi fail", 8'h02, regs_r.history)
      xfer(`ADDR_HISTORY, 1'b1, 16, 8'h02);
      pulse(16'hFFDF, '0);
      `CHK("supply a", 8'h5F, regs_r.supply_a)
      `CHK("supply b", 8'hFB, regs_r.supply_b)
      repeat (40) @(negedge clk);
      `CHK("thermal", 8'h07, regs_r.thermal)
      xfer(`ADDR_THERMAL, 1'b1, 16, 8'h07);
      xfer(`ADDR_SUPPLY_A, 1'b1, 16, 8'h5F);
      `CHK("after clear", 32'h00FB_0000, regs_r)
      pulse('0, 11'h001);
      `CHK("soft reset", 32'h0000_0000, regs_r)
      mode = MODE_SLEEP;
      main_reg_off = 1'b1;
      pulse(16'h0810, '0);
      `CHK("sleep block", 16'h0000, {regs_r.supply_a, regs_r.supply_b})
      mode = MODE_RESTART;
      main_reg_off = 1'b0;
      pulse(16'h0010, '0);
      mode = MODE_INIT;
      reset_output = 1'b0;
      pulse(16'h0010, '0);
      `CHK("uv blocked", 8'h00, regs_r.supply_b)
      reset_output = 1'b1;
      repeat (4) @(negedge clk);
      pulse(16'h0010, '0);
      xfer(`ADDR_SUPPLY_B, 1'b1, 16, 8'h01);
      mode = MODE_NORMAL;
      sev = 16'h0020;
      repeat (10) @(negedge clk);
      `CHK("short early", 1'b0, regs_r.supply_b[2])
      repeat (20) @(negedge clk);
      `CHK("short", 1'b1, regs_r.supply_b[2])
      sev = '0;
      xfer(`ADDR_SUPPLY_B, 1'b1, 16, 8'h04);
      for (int i = 0; i < 6; i++) begin
         pulse('0, hv[i]);
         xfer(`ADDR_HISTORY, 1'b1, 16, {code[i], 6'h00});
      end
      pulse('0, 11'h400);
      `CHK("wd one", 8'h04, regs_r.history)
      pulse('0, 11'h400);
      pulse('0, 11'h400);
      `CHK("wd two", 8'h09, regs_r.history)
      xfer(`ADDR_HISTORY, 1'b1, 16, 8'h09);
      `CHK("wd kept", 8'h08, regs_r.history)
      pulse('0, 11'h200);
      pulse('0, 11'h400);
      pulse('0, 11'h180);
      `CHK("stop by fail", 8'h04, regs_r.history)
      pulse('0, 11'h100);
      `CHK("stop", 8'h00, regs_r.history)
      wd_config = 2'h1;
      pulse('0, 11'h400);
      pulse('0, 11'h100);
      `CHK("cfg2 frozen", 8'h05, regs_r.history)
      pulse('0, 11'h200);
      xfer(`ADDR_HISTORY, 1'b1, 16, 8'h01);
      cfg_strap = 1'b0;
      repeat (4) @(negedge clk);
      pulse('0, 11'h400);
      `CHK("strap low", 8'h04, regs_r.history)
      cfg_strap = 1'b1;
      pulse('0, 11'h040);
      `CHK("fail output", 8'h05, regs_r.history)
      give_verdict();
   end
   // Full run needs about 60 us; allow several times that
   initial begin
      #400000;
      fails++;
      give_verdict();
   end
endmodule
bind supply_status_regs supply_status_asserts supply_status_asserts_inst (
   .clk(clk), .sys_rst(sys_rst), .wd_config(wd_config), .mode(mode),
   .main_reg_off(main_reg_off), .spi_csn_n(spi_csn_n), .sev(sev), .hev(hev),
   .regs_r(regs_r), .failsafe_req_r(failsafe_req_r),
   .watchdog_failure_counter_output_req_r(watchdog_failure_counter_output_req_r));
`default_nettype wire
